/* rtl/gd_ctrl_pkg.sv */
// shared constants and carrier types for the gate driver controller
package gd_ctrl_pkg;

   // ==========================================================
   // timing
   localparam int unsigned CLK_HZ            = 25_000_000;
   localparam int unsigned CLK_NS            = 40;
   localparam int unsigned DEGLITCH_NS       = 40;
   // a pulse must outlast the driver's glitch filter: round up, at least one cycle
   localparam int unsigned DEGLITCH_CYC_RAW  = (DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned DEGLITCH_CYC      = (DEGLITCH_CYC_RAW < 1) ? 1 : DEGLITCH_CYC_RAW;
   localparam int unsigned FAULT_MUTE_US     = 1;
   localparam int unsigned FAULT_MUTE_CYC    = (FAULT_MUTE_US * (CLK_HZ / 1_000_000));
   // reset pulse held well beyond the filter so the driver accepts it
   localparam int unsigned CLR_PULSE_CYC     = 4 * DEGLITCH_CYC;
   localparam int unsigned CNT_W             = 16;
   localparam logic [CNT_W-1:0] CNT_ZERO     = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE      = 16'h0001;

   // ==========================================================
   // pin bundles
   typedef struct packed {
      logic pwm_pos;     // non-inverting input drive
      logic pwm_neg;     // inverting input drive
      logic clr_en;      // clear/enable drive, active low clear
   } drv_pins_s;

   typedef struct packed {
      logic fault_flag;  // synchronised fault flag level, low = fault
      logic power_good;  // synchronised power good level, high = good
   } drv_flags_s;

   typedef enum logic [1:0] {
      MODE_MANUAL,
      MODE_AUTO_POS,
      MODE_AUTO_NEG
   } reset_mode_e;

endpackage : gd_ctrl_pkg

/* rtl/pin_sync.sv */
// two flip-flop synchroniser for the open-drain flags read back from the driver
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    nrst,
   // raw pins
   input  wire logic                    fault_flag_out,
   input  wire logic                    power_good_out,
   // synchronised levels
   output gd_ctrl_pkg::drv_flags_s      flags
);
   gd_ctrl_pkg::drv_flags_s meta_q;
   gd_ctrl_pkg::drv_flags_s sync_q;

   // the released fault flag reads high through the pullup, so it resets to that idle level; power good resets low
   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_q <= '{fault_flag: 1'b1, power_good: 1'b0};
         sync_q <= '{fault_flag: 1'b1, power_good: 1'b0};
      end else begin
         meta_q <= '{fault_flag: fault_flag_out, power_good: power_good_out};
         sync_q <= meta_q;
      end
   end

   assign flags = sync_q;
endmodule : pin_sync
`default_nettype wire

/* rtl/gd_ctrl.sv */
// controller that drives an isolated gate driver's inputs and watches its flags
`timescale 1ns/1ps
`default_nettype none
module gd_ctrl (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    nrst,
   // user side
   input  wire logic                    pwm_own,
   input  wire logic                    pwm_other,
   input  wire logic                    use_interlock,
   input  wire logic                    enable,
   input  wire gd_ctrl_pkg::reset_mode_e reset_mode,
   input  wire logic                    clear_req,
   output logic                         fault_active,
   output logic                         power_good,
   output logic                         clear_busy,
   output logic                         gate_expected,
   // driver pins
   input  wire logic                    fault_flag_out,
   input  wire logic                    power_good_out,
   output gd_ctrl_pkg::drv_pins_s       pins
);
   // ==========================================================
   // flag inputs
   gd_ctrl_pkg::drv_flags_s flags;

   pin_sync u_sync (
      .clk            (clk),
      .nrst           (nrst),
      .fault_flag_out (fault_flag_out),
      .power_good_out (power_good_out),
      .flags          (flags)
   );

   // the flags are released-high open-drain lines; low fault means latched
   wire fault_seen = !flags.fault_flag;
   wire pg_seen    = flags.power_good;

   // ==========================================================
   // clear sequencer
   typedef enum logic [1:0] {
      S_IDLE,
      S_MUTE,
      S_PULSE
   } clr_state_e;

   clr_state_e               state_q;
   clr_state_e               state_d;
   logic [gd_ctrl_pkg::CNT_W-1:0] cnt_q;
   logic [gd_ctrl_pkg::CNT_W-1:0] cnt_d;
   logic                     fault_prev_q;

   wire fault_rise = fault_seen && !fault_prev_q;
   wire cnt_done   = (cnt_q == gd_ctrl_pkg::CNT_ONE);
   // full counter width: a bare wire here would cut the count to one bit
   wire [gd_ctrl_pkg::CNT_W-1:0] cnt_dec = (cnt_q == gd_ctrl_pkg::CNT_ZERO) ? cnt_q :
                                           cnt_q - gd_ctrl_pkg::CNT_ONE;
   wire manual     = (reset_mode == gd_ctrl_pkg::MODE_MANUAL);

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_dec;
      unique case (state_q)
         S_IDLE: begin
            // mute time counts from the fault edge, never from the request
            if (manual && fault_rise) begin
               state_d = S_MUTE;
               cnt_d   = gd_ctrl_pkg::CNT_W'(gd_ctrl_pkg::FAULT_MUTE_CYC);
            end else if (manual && clear_req && fault_seen) begin
               state_d = S_PULSE;
               cnt_d   = gd_ctrl_pkg::CNT_W'(gd_ctrl_pkg::CLR_PULSE_CYC);
            end
         end
         S_MUTE: begin
            if (cnt_done && clear_req) begin
               state_d = S_PULSE;
               cnt_d   = gd_ctrl_pkg::CNT_W'(gd_ctrl_pkg::CLR_PULSE_CYC);
            end else if (cnt_done || cnt_q == gd_ctrl_pkg::CNT_ZERO) begin
               cnt_d = gd_ctrl_pkg::CNT_ZERO;
               if (clear_req) begin
                  state_d = S_PULSE;
                  cnt_d   = gd_ctrl_pkg::CNT_W'(gd_ctrl_pkg::CLR_PULSE_CYC);
               end
            end
         end
         S_PULSE: begin
            // pulse longer than the glitch filter so the driver takes it
            if (cnt_done) begin
               state_d = S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q      <= S_IDLE;
         cnt_q        <= gd_ctrl_pkg::CNT_ZERO;
         fault_prev_q <= 1'b0;
      end else begin
         state_q      <= state_d;
         cnt_q        <= cnt_d;
         fault_prev_q <= fault_seen;
      end
   end

   // ==========================================================
   // pin levels
   // without interlock the negative input is held at ground, never floated
   wire neg_level = use_interlock ? pwm_other : 1'b0;
   wire pos_level = pwm_own;
   // auto modes reuse the PWM so every switching cycle clears a fault, except MODE_AUTO_NEG without interlock, where clear/enable just follows enable
   wire auto_en   = (reset_mode == gd_ctrl_pkg::MODE_AUTO_POS) ? pwm_own : !neg_level;
   wire clr_level = (state_q == S_PULSE) ? 1'b0 :
                    (manual ? enable : (enable && auto_en));

   // clear/enable is always driven; the driver's pulldown only covers reset time
   gd_ctrl_pkg::drv_pins_s pins_q;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pins_q <= '{pwm_pos: 1'b0, pwm_neg: 1'b0, clr_en: 1'b0};
      end else begin
         pins_q <= '{pwm_pos: pos_level, pwm_neg: neg_level, clr_en: clr_level};
      end
   end

   assign pins = pins_q;

   // ==========================================================
   // status, registered
   logic fault_q;
   logic pg_q;
   logic busy_q;
   logic gate_q;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         fault_q <= 1'b0;
         pg_q    <= 1'b0;
         busy_q  <= 1'b0;
         gate_q  <= 1'b0;
      end else begin
         fault_q <= fault_seen;
         pg_q    <= pg_seen;
         busy_q  <= (state_q != S_IDLE);
         // expected gate level as the driver would compute it
         gate_q  <= pins_q.pwm_pos && !pins_q.pwm_neg && pins_q.clr_en
                    && pg_seen && !fault_seen;
      end
   end

   assign fault_active  = fault_q;
   assign power_good    = pg_q;
   assign clear_busy    = busy_q;
   assign gate_expected = gate_q;
endmodule : gd_ctrl
`default_nettype wire

/* test/gd_ctrl_properties.sv */
// port assertions for the gate driver controller
`timescale 1ns/1ps
`default_nettype none
module gd_ctrl_properties (
   // clock and reset
   input wire logic                     clk,
   input wire logic                     nrst,
   // watched ports
   input wire logic                     pwm_own,
   input wire logic                     pwm_other,
   input wire logic                     use_interlock,
   input wire logic                     enable,
   input wire gd_ctrl_pkg::reset_mode_e reset_mode,
   input wire logic                     fault_active,
   input wire gd_ctrl_pkg::drv_pins_s   pins
);
   // ====
   // helpers
   logic [7:0] fcnt_q;
   wire        man_en = reset_mode == gd_ctrl_pkg::MODE_MANUAL && enable;
   always_ff @(posedge clk) fcnt_q <= (!nrst || !fault_active) ? 8'h00 : fcnt_q + 8'h01;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   tie_low_a: assert property (!use_interlock |=> !pins.pwm_neg)
      else $error("negative input not held low");
   other_neg_a: assert property (use_interlock |=> pins.pwm_neg == $past(pwm_other))
      else $error("negative input not opposite pwm");
   own_pos_a: assert property (nrst |=> pins.pwm_pos == $past(pwm_own))
      else $error("positive input not own pwm");
   auto_pos_a: assert property (reset_mode == gd_ctrl_pkg::MODE_AUTO_POS |=>
      pins.clr_en == $past(enable && pwm_own)) else $error("auto positive clear wrong");
   auto_neg_a: assert property (reset_mode == gd_ctrl_pkg::MODE_AUTO_NEG |=>
      pins.clr_en == $past(enable && !(use_interlock && pwm_other)))
      else $error("auto negative clear wrong");
   off_hold_a: assert property (!enable |=> !pins.clr_en)
      else $error("clear enable high while disabled");
   mute_wait_a: assert property ($past(man_en) && $past(enable, 2) && $fell(pins.clr_en)
      |-> fcnt_q >= 8'h17) else $error("clear pulse inside mute interval");
   pulse_len_a: assert property ($past(man_en) && $past(enable, 2) && $fell(pins.clr_en)
      |-> !pins.clr_en [*4]) else $error("clear pulse too short");
   cover property ($rose(fault_active));
   cover property ($past(man_en) && $fell(pins.clr_en));
   cover property (reset_mode == gd_ctrl_pkg::MODE_AUTO_NEG && pins.clr_en);
endmodule : gd_ctrl_properties
`default_nettype wire

/* test/gd_device_model.sv */
// behavioural model of the isolated gate driver's input side
`timescale 1ns/1ps
`default_nettype none
module gd_device_model (
   // controller drive
   input wire gd_ctrl_pkg::drv_pins_s pins,
   // injected conditions
   input wire logic                   oc_event,
   input wire logic                   uvlo,
   // device outputs
   output logic                       fault_flag_out,
   output logic                       power_good_out,
   output logic                       gate
);
   // ====
   // filter, latch and gate
   gd_ctrl_pkg::drv_pins_s pins_f;
   logic                   flt_q = 1'b0;
   // inertial delay drops pulses shorter than the filter
   assign #40 pins_f = pins;
   // only a driven high enables; floating reads as the pulldown
   wire en = pins_f.clr_en === 1'b1;
   always @(posedge oc_event or negedge en) flt_q <= en && oc_event;
   assign gate = pins_f.pwm_pos && !pins_f.pwm_neg && en && !uvlo && !flt_q;
   // open drain: released level comes from the pull-up
   assign fault_flag_out = flt_q ? 1'b0 : 1'b1;
   assign power_good_out = uvlo ? 1'b0 : 1'b1;
endmodule : gd_device_model
`default_nettype wire

/* test/gd_ctrl_bench.sv */
// self-checking bench for the gate driver controller
`timescale 1ns/1ps
`default_nettype none
module gd_ctrl_bench;
   // ====
   // signals
   logic clk = 1'b0, nrst = 1'b0, busy_d = 1'b0, oc_event = 1'b0, uvlo = 1'b0;
   logic pwm_own = 1'b0, pwm_other = 1'b0, use_interlock = 1'b0, enable = 1'b0;
   logic clear_req = 1'b0, fault_active, power_good, clear_busy;
   logic fault_flag_out, power_good_out, gate, gate_expected, exp_g = 1'b0;
   gd_ctrl_pkg::reset_mode_e reset_mode = gd_ctrl_pkg::MODE_MANUAL;
   gd_ctrl_pkg::drv_pins_s   pins, exp_q;
   int n_errors = 0, n_tests = 0, cycles = 0, i, seed = 32'hbd3bcd74;
   always #20 clk = ~clk;
   gd_ctrl u_dut (.clk(clk), .nrst(nrst), .pwm_own(pwm_own), .pwm_other(pwm_other),
      .use_interlock(use_interlock), .enable(enable), .reset_mode(reset_mode),
      .clear_req(clear_req), .fault_active(fault_active), .power_good(power_good),
      .clear_busy(clear_busy), .gate_expected(gate_expected), .fault_flag_out(fault_flag_out),
      .power_good_out(power_good_out), .pins(pins));
   gd_device_model u_dev (.pins(pins), .oc_event(oc_event), .uvlo(uvlo),
      .fault_flag_out(fault_flag_out), .power_good_out(power_good_out), .gate(gate));
   task automatic check(input logic [2:0] seen, input logic [2:0] want);
      n_tests++;
      if (seen !== want) begin
         n_errors++;
         $display("Error %0t: saw %b expected %b", $time, seen, want);
      end
   endtask : check
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask : step
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   // ====
   // reference model: pins follow the inputs of the previous edge
   // sampled on the falling edge, where the registered outputs have settled
   always @(negedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         complete_run();
      end
      // a clear sequence owns the enable pin, so it is left out here
      if (nrst && !clear_busy && !busy_d && !fault_active) check(pins, exp_q);
      // gate level trails the pins by one cycle; flags are held off while they disagree
      if (nrst && power_good && !fault_active)
         check({2'h0, gate_expected}, {2'h0, exp_g});
      busy_d <= clear_busy;
      exp_g = pins.pwm_pos && !pins.pwm_neg && pins.clr_en;
      exp_q = 3'h0;
      if (nrst) begin
         exp_q.pwm_pos = pwm_own;
         exp_q.pwm_neg = use_interlock && pwm_other;
         exp_q.clr_en = enable && (reset_mode == gd_ctrl_pkg::MODE_AUTO_POS ? pwm_own :
            reset_mode == gd_ctrl_pkg::MODE_AUTO_NEG ? !exp_q.pwm_neg : 1'b1);
      end
   end
   // ====
   // scenarios
   initial begin
      step(4);
      nrst = 1'b1;
      check(pins, 3'h0);
      repeat (400) begin
         step(1);
         i = $random(seed);
         {pwm_own, pwm_other, use_interlock, enable} = i[5:2];
         reset_mode = gd_ctrl_pkg::reset_mode_e'(i[1:0] == 2'h3 ? 2'h0 : i[1:0]);
      end
      $display("test random done");
      step(1);
      {pwm_own, pwm_other, use_interlock, enable} = 4'h9;
      reset_mode = gd_ctrl_pkg::MODE_MANUAL;
      clear_req = 1'b1;
      step(3);
      oc_event = 1'b1;
      for (i = 0; i < 10 && fault_active !== 1'b1; i++) step(1);
      oc_event = 1'b0;
      check({fault_active, fault_flag_out, gate}, 3'h4);
      step(10);
      check({fault_active, clear_busy, fault_flag_out}, 3'h6);
      for (i = 0; i < 200 && (fault_active !== 1'b0 || clear_busy !== 1'b0); i++) step(1);
      check({fault_active, clear_busy, fault_flag_out}, 3'h1);
      clear_req = 1'b0;
      $display("test fault done");
      uvlo = 1'b1;
      step(4);
      check({power_good, gate, power_good_out}, 3'h0);
      uvlo = 1'b0;
      step(4);
      check({power_good, gate, power_good_out}, 3'h7);
      $display("test supply done");
      complete_run();
   end
endmodule : gd_ctrl_bench
bind gd_ctrl gd_ctrl_properties u_props (.*);
`default_nettype wire
